// ===== src/swpe_monitor.sv
/*
  run-time power estimator: per-signal switching-activity counters,
  interval timer, weighted sum and the read-only estimate output.
  assumes mon_sig comes from logic on clk_sys (no synchroniser) and that
  a bus subordinate outside presents estimate as a read-only word.
*/
// What this block does
// - one activity counter per selected monitored signal
// - single-toggle: add one if any bit changed
// - single-toggle grows at most one per cycle
// - hamming-weight: add count of changed bits
// - counter kind chosen per signal by mask
// - capture every counter at interval end
// - multiply activities by weights, sum them
// - estimate updated once per time interval
// - estimate read-only, writes cannot alter it
// - plain memory read serves estimate, no instructions
`timescale 1ns/1ns
`include "swpe_defs.svh"

module swpe_monitor
#(
  parameter int NUM_SIG = `SWPE_NUM_SIG,
  parameter int SIG_W = `SWPE_SIG_W,
  parameter int WT_W = `SWPE_WT_W,
  parameter int INTERVAL_CYC = `SWPE_INTERVAL_CYC,
  parameter logic [NUM_SIG-1:0] HAMMING_MASK = `SWPE_HAMMING_MASK,
  parameter logic [NUM_SIG*WT_W-1:0] WEIGHTS = `SWPE_WEIGHTS_DEFAULT,
  parameter int ST_W = $clog2(INTERVAL_CYC + 1),
  parameter int HW_W = $clog2(INTERVAL_CYC * SIG_W + 1),
  parameter int EST_W = HW_W + WT_W + $clog2(NUM_SIG + 1)
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_SIG*SIG_W-1:0] mon_sig,
  output logic [EST_W-1:0] estimate,
  output logic estimate_valid,
  output logic interval_tick,
  output logic [NUM_SIG-1:0] counter_kind,
  output logic busy,
  output logic overrun
);
  import swpe_pkg::*;

  localparam int SNAP_W = HW_W;
  localparam int IDX_W = (NUM_SIG > 1) ? $clog2(NUM_SIG) : 1;
  localparam int TMR_W = (INTERVAL_CYC > 1) ? $clog2(INTERVAL_CYC) : 1;
  localparam int POP_W = $clog2(SIG_W + 1);
  localparam int PROD_W = SNAP_W + WT_W;

  // number of bits set in a changed-bit vector
  function automatic logic [POP_W-1:0] popcount(input logic [SIG_W-1:0] v);
    logic [POP_W-1:0] n;
    n = '0;
    for (int b = 0; b < SIG_W; b++)
    begin
      n = n + POP_W'(v[b]);
    end
    return n;
  endfunction

  // weighted product of one snapshot and one weight, sized to the sum
  function automatic logic [EST_W-1:0] weigh(
    input logic [SNAP_W-1:0] act,
    input logic [WT_W-1:0] wt
  );
    logic [PROD_W-1:0] p;
    p = PROD_W'(act) * PROD_W'(wt);
    return EST_W'(p);
  endfunction

  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic tick;
  logic [SNAP_W-1:0] acc_upd [NUM_SIG];
  logic [SNAP_W-1:0] snap_reg [NUM_SIG];
  swpe_state_type state_reg;
  swpe_state_type state_next;
  logic [IDX_W-1:0] idx_reg;
  logic [EST_W-1:0] sum_reg;
  logic [EST_W-1:0] estimate_reg;
  logic valid_reg;
  logic overrun_reg;
  logic [WT_W-1:0] wt_data;
  logic last_idx;

  // interval timer: wraps every INTERVAL_CYC cycles
  assign tick = (tmr_reg == TMR_W'(INTERVAL_CYC - 1));
  assign tmr_next = tick ? `SWPE_ZERO : tmr_reg + TMR_W'(1);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tmr_reg <= `SWPE_ZERO;
    end
    else
    begin
      tmr_reg <= tmr_next;
    end
  end

  // one counter per monitored signal, kind picked by the mask
  for (genvar g = 0; g < NUM_SIG; g++)
  begin : gen_cnt
    localparam int W = HAMMING_MASK[g] ? HW_W : ST_W;
    logic [SIG_W-1:0] cur;
    logic [SIG_W-1:0] prev_reg;
    logic [SIG_W-1:0] flip;
    logic [W-1:0] inc;
    logic [W-1:0] acc_reg;
    logic [W-1:0] acc_sum;

    // per-bit change against the previous cycle
    assign cur = mon_sig[g*SIG_W +: SIG_W];
    assign flip = cur ^ prev_reg;

    if (HAMMING_MASK[g])
    begin : gen_hw
      // count of toggled bits added each cycle
      assign inc = W'(popcount(flip));
    end
    else
    begin : gen_st
      // or-reduced toggle, at most one per cycle, width set by window only
      assign inc = W'(|flip);
    end

    assign acc_sum = acc_reg + inc;
    assign acc_upd[g] = SNAP_W'(acc_sum);

    // previous-cycle copy of the monitored signal
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        prev_reg <= `SWPE_ZERO;
      end
      else
      begin
        prev_reg <= cur;
      end
    end

    // accumulate inside the interval, restart once it has been captured
    always_ff @(posedge clk_sys)
    begin
      if (rst || tick)
      begin
        acc_reg <= `SWPE_ZERO;
      end
      else
      begin
        acc_reg <= acc_sum;
      end
    end
  end

  // snapshot takes the last cycle's activity too, so no toggle is lost
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_SIG; i++)
      begin
        snap_reg[i] <= `SWPE_ZERO;
      end
    end
    else if (tick)
    begin
      for (int i = 0; i < NUM_SIG; i++)
      begin
        snap_reg[i] <= acc_upd[i];
      end
    end
  end

  // weight table, registered read
  swpe_weight_rom #(
    .DEPTH(NUM_SIG),
    .WT_W(WT_W),
    .ADDR_W(IDX_W),
    .WEIGHTS(WEIGHTS)
  ) u_weights (
    .clk_sys(clk_sys),
    .rst(rst),
    .addr(idx_reg),
    .rd_data(wt_data)
  );

  assign last_idx = (idx_reg == IDX_W'(NUM_SIG - 1));

  // sequencer: fetch a weight, accumulate its product, then publish
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SWPE_IDLE:
      begin
        if (tick)
        begin
          state_next = SWPE_FETCH;
        end
      end
      SWPE_FETCH:
      begin
        state_next = SWPE_ACCUM;
      end
      SWPE_ACCUM:
      begin
        state_next = last_idx ? SWPE_PUBLISH : SWPE_FETCH;
      end
      SWPE_PUBLISH:
      begin
        state_next = SWPE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= SWPE_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // signal index walked by the sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      idx_reg <= `SWPE_ZERO;
    end
    else if (state_reg == SWPE_IDLE)
    begin
      idx_reg <= `SWPE_ZERO;
    end
    else if (state_reg == SWPE_ACCUM && !last_idx)
    begin
      idx_reg <= idx_reg + IDX_W'(1);
    end
  end

  // running weighted sum over all counters
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sum_reg <= `SWPE_ZERO;
    end
    else if (state_reg == SWPE_IDLE)
    begin
      sum_reg <= `SWPE_ZERO;
    end
    else if (state_reg == SWPE_ACCUM)
    begin
      sum_reg <= sum_reg + weigh(snap_reg[idx_reg], wt_data);
    end
  end

  // estimate register: only the sequencer loads it, no write path exists
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      estimate_reg <= `SWPE_ZERO;
    end
    else if (state_reg == SWPE_PUBLISH)
    begin
      estimate_reg <= sum_reg;
    end
  end

  // one-cycle pulse when a fresh estimate is loaded
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      valid_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= (state_reg == SWPE_PUBLISH);
    end
  end

  // sticky flag: interval ended while the previous sum was still running
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      overrun_reg <= 1'b0;
    end
    else if (tick && state_reg != SWPE_IDLE)
    begin
      overrun_reg <= 1'b1;
    end
  end

  // outputs: estimate held steady between updates for a plain read
  assign estimate = estimate_reg;
  assign estimate_valid = valid_reg;
  assign interval_tick = tick;
  assign counter_kind = HAMMING_MASK;
  assign busy = (state_reg != SWPE_IDLE);
  assign overrun = overrun_reg;

endmodule

// ===== src/swpe_defs.svh
/*
  constants for the switching-activity power estimator: clock rate,
  time resolution, default monitored-signal set and model weights.
  assumes it is included by bare name from the package and the modules.
*/
`ifndef SWPE_DEFS_SVH
`define SWPE_DEFS_SVH

// clock period and estimate time resolution, both in nanoseconds
`define SWPE_CLK_PERIOD_NS 50
`define SWPE_TIME_RES_NS 10000

// cycles per estimate interval, rounded down (longest time)
`define SWPE_INTERVAL_CYC (`SWPE_TIME_RES_NS / `SWPE_CLK_PERIOD_NS)

// default shape of the monitored signal set
`define SWPE_NUM_SIG 4
`define SWPE_SIG_W 8
`define SWPE_WT_W 16

// per-signal counter kind mask: bit set means hamming-weight counter
`define SWPE_HAMMING_MASK 4'h5

// default model weights, signal 0 in the low slice; values are arbitrary
`define SWPE_WEIGHTS_DEFAULT 64'h0004_0003_0002_0001

// value of every cleared accumulator, snapshot and estimate
`define SWPE_ZERO '0

`endif

// ===== src/swpe_pkg.sv
/*
  types shared by the estimator modules.
  assumes swpe_defs.svh is on the include path.
*/
`include "swpe_defs.svh"

package swpe_pkg;

  // sequencing of the weighted sum after each interval
  typedef enum logic [1:0] {
    SWPE_IDLE,
    SWPE_FETCH,
    SWPE_ACCUM,
    SWPE_PUBLISH
  } swpe_state_type;

  // counter kind chosen per monitored signal
  typedef enum logic {
    SWPE_SINGLE_TOGGLE,
    SWPE_HAMMING_WEIGHT
  } swpe_kind_type;

endpackage

// ===== src/swpe_weight_rom.sv
/*
  constant table of model weights, one word per monitored signal.
  assumes addr comes from logic on clk_sys; rd_data is registered,
  so data for an address appears one edge after it is presented.
*/
`timescale 1ns/1ns
`include "swpe_defs.svh"

module swpe_weight_rom
#(
  parameter int DEPTH = `SWPE_NUM_SIG,
  parameter int WT_W = `SWPE_WT_W,
  parameter int ADDR_W = 2,
  parameter logic [DEPTH*WT_W-1:0] WEIGHTS = `SWPE_WEIGHTS_DEFAULT
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  output logic [WT_W-1:0] rd_data
);

  // registered read of the selected weight slice
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_data <= `SWPE_ZERO;
    end
    else
    begin
      rd_data <= WEIGHTS[addr*WT_W +: WT_W];
    end
  end

endmodule

// ===== verification/swpe_monitor_checker.sv
/* timing checks on the estimator ports.
   assumes INTERVAL_CYC 16 and NUM_SIG 4 in the bench. */
`timescale 1ns/1ns
module swpe_monitor_checker
#(
  parameter int NUM_SIG = 4,
  parameter int SIG_W = 8,
  parameter int EST_W = 27
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_SIG*SIG_W-1:0] mon_sig,
  input wire logic [EST_W-1:0] estimate,
  input wire logic estimate_valid,
  input wire logic interval_tick,
  input wire logic [NUM_SIG-1:0] counter_kind,
  input wire logic busy,
  input wire logic overrun
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // interval, sum and publish sequencing
  tick_period_a: assert property (interval_tick |-> ##16 interval_tick)
    else $error("tick period wrong");
  publish_delay_a: assert property (interval_tick |-> ##10 estimate_valid)
    else $error("publish late");
  valid_cause_a: assert property (estimate_valid |-> $past(interval_tick, 10))
    else $error("publish without tick");
  valid_pulse_a: assert property (estimate_valid |=> !estimate_valid)
    else $error("publish too long");
  sum_busy_a: assert property (interval_tick |=> busy [*8] ##1 busy ##1 !busy)
    else $error("busy window wrong");
  // the edge after a reset sees the cleared estimate against its old value
  estimate_hold_a: assert property (!estimate_valid && !$past(rst) |-> $stable(estimate))
    else $error("estimate moved");
  kind_mask_a: assert property (counter_kind == 4'h5)
    else $error("kind mask wrong");
  no_overrun_a: assert property (!overrun)
    else $error("overrun set");
  // main scenarios seen
  cover property (estimate_valid && estimate != '0);
  cover property (interval_tick && busy == 1'b0);
  cover property (estimate_valid && estimate == '0);
endmodule
bind swpe_monitor swpe_monitor_checker #(.NUM_SIG(NUM_SIG), .SIG_W(SIG_W), .EST_W(EST_W))
  u_chk (.clk_sys(clk_sys), .rst(rst), .mon_sig(mon_sig), .estimate(estimate),
  .estimate_valid(estimate_valid), .interval_tick(interval_tick),
  .counter_kind(counter_kind), .busy(busy), .overrun(overrun));

// ===== verification/swpe_reader.sv
/* far-side reader: a manager fetching each new estimate.
   assumes estimate holds between publish pulses. */
`timescale 1ns/1ns
module swpe_reader
#(
  parameter int EST_W = 27
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [EST_W-1:0] estimate,
  input wire logic estimate_valid,
  output logic [EST_W-1:0] rd_word_reg
);
  // plain read of the published word, never a write
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rd_word_reg <= '0;
    else if (estimate_valid)
      rd_word_reg <= estimate;
  end
endmodule

// ===== verification/test_switching_activity_power_estimator.sv
/* bench for the estimator: toggle masks per row, reset cases.
   assumes INTERVAL_CYC 16, weights 1..4, signals 0 and 2 hamming. */
`timescale 1ns/1ns
module test_switching_activity_power_estimator;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] mon_sig = 32'h0000_0003;
  logic [31:0] tmask = 32'h0;
  logic [26:0] estimate;
  logic [26:0] rd_word;
  logic estimate_valid;
  logic interval_tick;
  logic busy;
  logic overrun;
  logic [3:0] counter_kind;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] rm [6] = '{32'h1, 32'hff00, 32'hff_0000, 32'h8000_0000, 32'hffff_ffff, 32'h0};
  logic [31:0] re [6] = '{32'h10, 32'h20, 32'h180, 32'h40, 32'h260, 32'h0};

  swpe_monitor #(.INTERVAL_CYC(16)) dut (.clk_sys(clk_sys), .rst(rst), .mon_sig(mon_sig),
    .estimate(estimate), .estimate_valid(estimate_valid), .interval_tick(interval_tick),
    .counter_kind(counter_kind), .busy(busy), .overrun(overrun));
  swpe_reader #(.EST_W(27)) u_rd (.clk_sys(clk_sys), .rst(rst), .estimate(estimate),
    .estimate_valid(estimate_valid), .rd_word_reg(rd_word));

  // clock and toggle stimulus
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) mon_sig <= #5 mon_sig ^ tmask;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_valid;
    int n;
    n = 0;
    @(posedge clk_sys);
    #5;
    while (estimate_valid !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      #5;
      n++;
    end
    if (n == 40) chk("valid wait", 32'h1, 32'h0);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog on a hung run
  initial
  begin
    #100000;
    error_cnt++;
    finish_test;
  end

  // main sequence: reset, rows, mid-run reset
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #5;
    chk("estimate in reset", 32'h0, estimate);
    chk("valid in reset", 32'h0, estimate_valid);
    rst = 1'b0;
    chk("kind mask", 32'h5, counter_kind);
    wait_valid;
    chk("first estimate", 32'h2, estimate);
    for (int i = 0; i < 6; i++)
    begin
      tmask = rm[i];
      repeat (3) wait_valid;
      chk("row estimate", re[i], estimate);
    end
    tmask = 32'hffff_ffff;
    repeat (20) @(posedge clk_sys);
    #5 rst = 1'b1;
    @(posedge clk_sys);
    #5;
    chk("estimate after reset", 32'h0, estimate);
    rst = 1'b0;
    repeat (2) wait_valid;
    chk("estimate after rerun", 32'h260, estimate);
    @(posedge clk_sys);
    #5;
    chk("reader copy", 32'h260, rd_word);
    chk("overrun", 32'h0, overrun);
    finish_test;
  end
endmodule
